/* core/gtm_timer.sv */
// General 16-bit timer with register port and channel interrupt word.
// Assumes the external timer clock is slow against clk_sys and is sampled.
`include "gtm_params.svh"
module gtm_timer (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire gtm_pkg::gtm_bus_req_t bus_req,
	output logic      [31:0]         rdata,
	input  wire logic                internal_tick,
	input  wire logic                external_timer_clock_pin,
	input  wire logic [23:0]         chan_code,
	input  wire logic [7:0]          channel_indicator_byte,
	input  wire logic                wake_event,
	input  wire logic                pin_event,
	input  wire logic [7:0]          pin_level_register,
	input  wire logic                pin_out_normal,
	input  wire logic                pin_oe_normal,
	output logic                     multipurpose_pin_zero_o,
	output logic                     multipurpose_pin_zero_oe,
	output logic                     timer_out,
	output logic                     host_irq
);
	import gtm_pkg::*;
	logic        rst_meta_reg;
	logic        rst_sync_n;
	logic [7:0]  timer_period_low_reg;
	logic [7:0]  timer_period_high_reg;
	gtm_mode_t   mode_reg;
	gtm_state_t  state_reg;
	logic [15:0] count_reg;
	logic        out_reg;
	logic        pend_reg;
	logic        wake_reg;
	logic        pin_reg;
	logic        ext_sync;
	logic        ext_prev_reg;
	logic [15:0] period;
	logic        tick;
	logic        wr_timer;
	logic        rd_timer;
	logic [3:0]  cmd;
	logic        cmd_ok;
	logic        running;
	logic        timeout;
	logic        rise;
	logic [15:0] half_p;
	logic [23:0] code_word;
	logic        timer_eff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	gtm_sync u_ext (
		.clk_sys (clk_sys),
		.rst_n   (rst_sync_n),
		.d       (external_timer_clock_pin),
		.q       (ext_sync)
	);

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n)
			ext_prev_reg <= 1'b0;
		else
			ext_prev_reg <= ext_sync;
	end

	// Internal source is a tick enable so the count stays in one clock domain.
	assign tick = mode_reg.ext_clk ? (ext_sync & ~ext_prev_reg) : internal_tick;
	assign period = {timer_period_high_reg, timer_period_low_reg};
	assign half_p = {1'b0, period[15:1]};
	assign wr_timer = bus_req.wr && (bus_req.addr == `GTM_ADDR_TIMER);
	assign rd_timer = bus_req.rd && (bus_req.addr == `GTM_ADDR_TIMER);
	assign cmd = bus_req.wdata[3:0];
	assign running = (state_reg != GTM_IDLE);
	// A running one-shot still accepts start, stop and reset; periodic only stop and reset.
	always_comb begin
		if (!running)
			cmd_ok = 1'b1;
		else if (mode_reg.oneshot)
			cmd_ok = (cmd == `GTM_CMD_START) || (cmd == `GTM_CMD_STOP) ||
				(cmd == `GTM_CMD_RESET);
		else
			cmd_ok = (cmd == `GTM_CMD_STOP) || (cmd == `GTM_CMD_RESET);
	end
	assign timeout = (state_reg == GTM_RUN) && tick && (count_reg == period - 16'h0001);
	assign rise = (state_reg == GTM_RUN) && !mode_reg.oneshot && timeout;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{timer_period_high_reg, timer_period_low_reg} <= `GTM_PERIOD_RESET;
		end else if (wr_timer && !running) begin
			timer_period_low_reg  <= bus_req.wdata[23:16];
			timer_period_high_reg <= bus_req.wdata[31:24];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode_reg <= '{irq_en: 1'b0, oneshot: 1'b0, ext_clk: 1'b0, routed: 1'b0};
		end else if (wr_timer && cmd_ok) begin
			case (cmd)
				`GTM_CMD_IRQ_EN:  mode_reg.irq_en  <= 1'b1;
				`GTM_CMD_IRQ_DIS: mode_reg.irq_en  <= 1'b0;
				`GTM_CMD_ONESHOT: mode_reg.oneshot <= 1'b1;
				`GTM_CMD_RETRIG:  mode_reg.oneshot <= 1'b0;
				`GTM_CMD_INTCLK:  mode_reg.ext_clk <= 1'b0;
				`GTM_CMD_EXTCLK:  mode_reg.ext_clk <= 1'b1;
				`GTM_CMD_ROUTE:   mode_reg.routed  <= 1'b1;
				`GTM_CMD_DEROUTE: mode_reg.routed  <= 1'b0;
				`GTM_CMD_RESET:   mode_reg <= '{irq_en: 1'b0, oneshot: 1'b0,
					ext_clk: 1'b0, routed: 1'b0};
				default:          mode_reg <= mode_reg;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= GTM_IDLE;
			count_reg <= 16'h0000;
			out_reg   <= 1'b1;
		end else if (wr_timer && cmd_ok && (cmd == `GTM_CMD_STOP || cmd == `GTM_CMD_RESET)) begin
			state_reg <= GTM_IDLE;
			count_reg <= 16'h0000;
			out_reg   <= 1'b1;
		end else if (wr_timer && cmd_ok && cmd == `GTM_CMD_START) begin
			if (state_reg != GTM_DONE && period != 16'h0000) begin
				state_reg <= GTM_RUN;
				count_reg <= 16'h0000;
				out_reg   <= 1'b1;
			end
		end else begin
			case (state_reg)
				GTM_RUN: begin
					if (tick) begin
						if (timeout) begin
							count_reg <= 16'h0000;
							out_reg   <= !mode_reg.oneshot;
							if (mode_reg.oneshot)
								state_reg <= GTM_DONE;
						end else begin
							count_reg <= count_reg + 16'h0001;
							if (!mode_reg.oneshot && count_reg == half_p - 16'h0001)
								out_reg <= 1'b0;
						end
					end
				end
				GTM_DONE: out_reg <= 1'b0;
				default:  out_reg <= 1'b1;
			endcase
		end
	end

	// New events win over a same-cycle clear.
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n)
			pend_reg <= 1'b0;
		else if (timeout || rise)
			pend_reg <= 1'b1;
		else if (rd_timer || (wr_timer && cmd_ok && cmd == `GTM_CMD_RESET))
			pend_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wake_reg <= 1'b0;
			pin_reg  <= 1'b0;
		end else begin
			if (wake_event)
				wake_reg <= 1'b1;
			else if (bus_req.rd && bus_req.addr == `GTM_ADDR_INTR)
				wake_reg <= 1'b0;
			if (pin_event)
				pin_reg <= 1'b1;
			else if (bus_req.rd && bus_req.addr == `GTM_ADDR_PINLVL)
				pin_reg <= 1'b0;
		end
	end

	assign timer_eff = pend_reg && mode_reg.irq_en;

	gtm_encoder #(.CHANNELS(8)) u_enc (
		.chan_code  (chan_code),
		.timer_pend (timer_eff),
		.pin_pend   (pin_reg),
		.code_word  (code_word)
	);

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n)
			rdata <= 32'h0000_0000;
		else if (bus_req.rd) begin
			case (bus_req.addr)
				`GTM_ADDR_TIMER:
					rdata <= {timer_period_high_reg, timer_period_low_reg, 8'h00,
						7'h00, timer_eff};
				`GTM_ADDR_INTR:
					rdata <= {code_word, channel_indicator_byte};
				// The level byte is returned so the clearing read also reports the pins.
				`GTM_ADDR_PINLVL:
					rdata <= {24'h00_0000, pin_level_register};
				default: rdata <= 32'h0000_0000;
			endcase
		end else
			rdata <= 32'h0000_0000;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			multipurpose_pin_zero_o  <= 1'b0;
			multipurpose_pin_zero_oe <= 1'b0;
		end else if (mode_reg.routed) begin
			multipurpose_pin_zero_o  <= out_reg;
			multipurpose_pin_zero_oe <= 1'b1;
		end else begin
			multipurpose_pin_zero_o  <= pin_out_normal;
			multipurpose_pin_zero_oe <= pin_oe_normal;
		end
	end

	assign timer_out = out_reg;
	// Wake alone raises the line even though its code reads as none.
	assign host_irq = (code_word != 24'h00_0000) || wake_reg ||
		(channel_indicator_byte != 8'h00);
endmodule

/* core/gtm_params.svh */
// Constants for the general timer and the channel interrupt encoder.
// Assumes a single 20 MHz system clock and a plain strobe register port.
// Summary of operation
// - Period is high byte over low byte.
// - Period reads return programmed value, reset untouched.
// - Period resets to zero; zero disables.
// - Counter clock internal or external pin.
// - Decode eleven four-bit commands; rest reserved.
// - Commands self-clear; read shows enabled pending.
// - Reset restores default mode and stops.
// - One-shot output high, low after N.
// - One-shot restart before timeout; stop restores.
// - Running one-shot blocks period and commands.
// - Periodic output high P, low Q.
// - Running periodic blocks period, start, commands.
// - Routed pin zero forced high output; code drives it with the timer output, enable high.
// - Interrupt after N, each rising edge.
// - Interrupt clears on control read or reset.
// - Timer code 111, pin code 110, channel zero.
// - Eight channels of three-bit source codes.
// - Wake clears on indicator read; pin on level.
// - Timer word byte lanes control reserved low high.
`ifndef GTM_PARAMS_SVH
`define GTM_PARAMS_SVH
`define GTM_ADDR_INTR      8'h80
`define GTM_ADDR_TIMER     8'h84
`define GTM_ADDR_PINLVL    8'h90
`define GTM_CMD_IRQ_EN     4'h1
`define GTM_CMD_IRQ_DIS    4'h2
`define GTM_CMD_ONESHOT    4'h3
`define GTM_CMD_RETRIG     4'h4
`define GTM_CMD_INTCLK     4'h5
`define GTM_CMD_EXTCLK     4'h6
`define GTM_CMD_ROUTE      4'h7
`define GTM_CMD_DEROUTE    4'h8
`define GTM_CMD_START      4'h9
`define GTM_CMD_STOP       4'ha
`define GTM_CMD_RESET      4'hb
`define GTM_CODE_NONE      3'h0
`define GTM_CODE_RX        3'h1
`define GTM_CODE_RXTO      3'h2
`define GTM_CODE_TX        3'h3
`define GTM_CODE_MODEM     3'h4
`define GTM_CODE_PIN       3'h6
`define GTM_CODE_TIMER     3'h7
`define GTM_PERIOD_RESET   16'h0000
`endif

/* core/gtm_pkg.sv */
// Types shared by the timer block.
// Assumes the constants header is included by users of these types.
package gtm_pkg;
	typedef enum logic [1:0] {GTM_IDLE, GTM_RUN, GTM_DONE} gtm_state_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} gtm_bus_req_t;
	typedef struct packed {
		logic       irq_en;
		logic       oneshot;
		logic       ext_clk;
		logic       routed;
	} gtm_mode_t;
endpackage

/* core/gtm_sync.sv */
// Two-flop synchroniser for one level.
// Assumes the input may change at any time relative to clk_sys.
module gtm_sync (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* core/gtm_encoder.sv */
// Channel interrupt source encoder for the global interrupt word.
// Assumes per-channel codes arrive already prioritised, except channel zero.
`include "gtm_params.svh"
module gtm_encoder #(
	parameter int CHANNELS = 8
) (
	input  wire logic [CHANNELS*3-1:0] chan_code,
	input  wire logic                  timer_pend,
	input  wire logic                  pin_pend,
	output logic      [CHANNELS*3-1:0] code_word
);
	import gtm_pkg::*;
	function automatic logic [2:0] pick(input logic [2:0] uart, input logic pin,
		input logic tmr);
		// Global sources rank below the channel zero source.
		if (uart != `GTM_CODE_NONE)
			pick = uart;
		else if (pin)
			pick = `GTM_CODE_PIN;
		else if (tmr)
			pick = `GTM_CODE_TIMER;
		else
			pick = `GTM_CODE_NONE;
	endfunction
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			if (g == 0) begin : gen_zero
				assign code_word[2:0] = pick(chan_code[2:0], pin_pend, timer_pend);
			end else begin : gen_other
				assign code_word[g*3 +: 3] = chan_code[g*3 +: 3];
			end
		end
	endgenerate
endmodule

/* dv/gtm_timer_sva.sv */
// Port assertions for the general timer block.
// Assumes one clock and the bind at the foot of this file.
`include "gtm_params.svh"
module gtm_timer_sva (
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	input wire gtm_pkg::gtm_bus_req_t bus_req,
	input wire logic [31:0]           rdata,
	input wire logic [23:0]           chan_code,
	input wire logic [7:0]            channel_indicator_byte,
	input wire logic                  pin_oe_normal,
	input wire logic                  multipurpose_pin_zero_o,
	input wire logic                  multipurpose_pin_zero_oe,
	input wire logic                  timer_out,
	input wire logic                  host_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import gtm_pkg::*;
	logic [23:0] code_q;
	logic [7:0]  ind_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk_sys) begin
		code_q <= chan_code;
		ind_q  <= channel_indicator_byte;
	end
	sequence s_rd(a);
		bus_req.rd && bus_req.addr == a;
	endsequence
	sequence s_cmd(c);
		bus_req.wr && bus_req.addr == `GTM_ADDR_TIMER && bus_req.wdata[3:0] == c;
	endsequence
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	timer_fmt_a: assert property (s_rd(`GTM_ADDR_TIMER) |=> rdata[15:1] == 15'h0000)
		else $error("timer status byte has stray bits");
	word_fmt_a: assert property (s_rd(`GTM_ADDR_INTR) |=>
		rdata[7:0] == ind_q && rdata[31:11] == code_q[23:3])
		else $error("interrupt word fields wrong");
	uart_first_a: assert property (s_rd(`GTM_ADDR_INTR) ##0 chan_code[2:0] != 3'h0
		|=> rdata[10:8] == code_q[2:0])
		else $error("channel zero code lost priority");
	irq_level_a: assert property (chan_code != 24'h00_0000 |-> host_irq)
		else $error("host interrupt low with a pending code");
	reset_cmd_a: assert property (s_cmd(`GTM_CMD_RESET) |-> ##[1:2] timer_out)
		else $error("timer output not high after reset command");
	stop_cmd_a: assert property (s_cmd(`GTM_CMD_STOP) |-> ##[1:2] timer_out)
		else $error("timer output not high after stop");
	pin_route_a: assert property (multipurpose_pin_zero_oe && !pin_oe_normal
		&& !$past(pin_oe_normal) |-> multipurpose_pin_zero_o == $past(timer_out))
		else $error("routed pin does not follow timer output");
endmodule
bind gtm_timer gtm_timer_sva u_gtm_timer_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.bus_req(bus_req), .rdata(rdata), .chan_code(chan_code),
	.channel_indicator_byte(channel_indicator_byte), .pin_oe_normal(pin_oe_normal),
	.multipurpose_pin_zero_o(multipurpose_pin_zero_o),
	.multipurpose_pin_zero_oe(multipurpose_pin_zero_oe), .timer_out(timer_out),
	.host_irq(host_irq));

/* dv/test_general_timer_with_irq_encoding.sv */
// Self-checking bench for the general timer block.
// Assumes a 20 MHz clock; the bench drives every port itself.
`include "gtm_params.svh"
module test_general_timer_with_irq_encoding;
	timeunit 1ns;
	timeprecision 1ns;
	import gtm_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n = 1'b0;
	gtm_bus_req_t bus_req = '0;
	logic [23:0]  chan_code = 24'h00_0000;
	logic [7:0]   ind = 8'h00;
	logic         pon = 1'b0;
	logic         poe = 1'b1;
	logic         ext_pin = 1'b0;
	logic         wev = 1'b0;
	logic         pev = 1'b0;
	logic [7:0]   lvl = 8'h00;
	logic [31:0]  rdata;
	logic [31:0]  d;
	logic         pin_o;
	logic         pin_oe;
	logic         t_out;
	logic         irq;
	int           fails = 0;
	int           checks_done = 0;
	int           seed = 32'h3670;
	int           n;
	int           cnt;
	always #25 clk_sys = ~clk_sys;
	// The external clock pin idles low and only pulses in the external-clock scenario.
	gtm_timer u_gtm_timer (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
		.internal_tick(1'b1), .external_timer_clock_pin(ext_pin), .chan_code(chan_code),
		.channel_indicator_byte(ind), .wake_event(wev), .pin_event(pev),
		.pin_level_register(lvl), .pin_out_normal(pon), .pin_oe_normal(poe),
		.multipurpose_pin_zero_o(pin_o), .multipurpose_pin_zero_oe(pin_oe),
		.timer_out(t_out), .host_irq(irq));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(logic r, logic [7:0] a, logic [31:0] w);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: w, wr: !r, rd: r};
		@(posedge clk_sys);
		bus_req <= '0;
		#1 d = rdata;
	endtask
	task automatic cmd(logic [3:0] c);
		acc(1'b0, `GTM_ADDR_TIMER, {n[15:0], 12'h000, c});
	endtask
	task automatic rdt(logic [15:0] low);
		acc(1'b1, `GTM_ADDR_TIMER, 32'h0000_0000);
		chk("timer word", {n[15:0], low}, d);
	endtask
	task automatic meas(logic lvl, output int c);
		c = 0;
		while (t_out === lvl && c < 200) begin
			@(posedge clk_sys);
			#1 c++;
		end
	endtask
	// Four cycles per pulse leave room for the two-flop synchroniser to see each edge.
	task automatic pulse();
		ext_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ext_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic end_sim();
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_sim();
	end
	initial begin
		pon <= 1'($random(seed));
		lvl <= 8'($random(seed));
		n = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rdt(16'h0000);
		chk("pin normal", {pon, 1'b1, 1'b1}, {pin_o, pin_oe, t_out});
		poe <= 1'b0;
		n = 5 + {$random(seed)} % 8;
		cmd(4'h0);
		rdt(16'h0000);
		cmd(`GTM_CMD_IRQ_EN);
		cmd(`GTM_CMD_ONESHOT);
		cmd(`GTM_CMD_ROUTE);
		cmd(`GTM_CMD_START);
		chk("routed", 2'b11, {pin_o, pin_oe});
		meas(1'b1, cnt);
		chk("one shot", n, cnt);
		chk("irq line", 1, irq);
		chan_code <= 24'($random(seed)) & 24'hff_fff8;
		ind <= 8'($random(seed));
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("int word", {chan_code[23:3], 3'h7, ind}, d);
		chan_code[2:0] <= 3'h1 + 3'({$random(seed)} % 4);
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("uart first", {chan_code, ind}, d);
		acc(1'b0, `GTM_ADDR_TIMER, 32'hffff_0004);
		rdt(16'h0001);
		rdt(16'h0000);
		cmd(`GTM_CMD_START);
		repeat (n + 3) @(posedge clk_sys);
		chk("late start", 0, t_out);
		chk("pin follows", 0, pin_o);
		cmd(`GTM_CMD_STOP);
		chk("stopped", 1, t_out);
		cmd(`GTM_CMD_RETRIG);
		cmd(`GTM_CMD_START);
		acc(1'b0, `GTM_ADDR_TIMER, 32'h0002_0003);
		meas(1'b0, cnt);
		meas(1'b1, cnt);
		meas(1'b0, cnt);
		chk("low phase", n - n / 2, cnt);
		meas(1'b1, cnt);
		chk("high phase", n / 2, cnt);
		cmd(`GTM_CMD_STOP);
		chk("idle high", 1, t_out);
		rdt(16'h0001);
		cmd(`GTM_CMD_DEROUTE);
		@(posedge clk_sys);
		#1 chk("derouted", {pon, 1'b0}, {pin_o, pin_oe});
		cmd(`GTM_CMD_EXTCLK);
		cmd(`GTM_CMD_START);
		repeat (2 * n) @(posedge clk_sys);
		chk("ext clock", 1, t_out);
		repeat (n / 2 - 1) pulse();
		#1 chk("ext early", 1, t_out);
		pulse();
		#1 chk("ext count", 0, t_out);
		cmd(`GTM_CMD_RESET);
		rdt(16'h0000);
		for (int c = 12; c < 16; c++) begin
			cmd(c[3:0]);
		end
		cmd(`GTM_CMD_IRQ_DIS);
		cmd(`GTM_CMD_INTCLK);
		cmd(`GTM_CMD_START);
		repeat (2 * n) @(posedge clk_sys);
		rdt(16'h0000);
		chan_code <= 24'h00_0003;
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("uart code", 3'h3, d[10:8]);
		chan_code <= 24'h00_0000;
		ind <= 8'h00;
		pev <= 1'b1;
		@(posedge clk_sys);
		pev <= 1'b0;
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("pin code", `GTM_CODE_PIN, d[10:8]);
		acc(1'b1, `GTM_ADDR_PINLVL, 32'h0000_0000);
		chk("pin level", {24'h00_0000, lvl}, d);
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("pin cleared", `GTM_CODE_NONE, d[10:8]);
		wev <= 1'b1;
		@(posedge clk_sys);
		wev <= 1'b0;
		#1 chk("wake line", 1, irq);
		acc(1'b1, `GTM_ADDR_INTR, 32'h0000_0000);
		chk("wake code", `GTM_CODE_NONE, d[10:8]);
		chk("irq idle", 0, irq);
		end_sim();
	end
endmodule
